// File: common/dram_wcd_pkg.sv
// Behaviour
// - row address held 20 ns, or 12 ns
// - delay bit postpones column strobe on hit/burst writes
// - delayed write also defers transfer acknowledge
// - alternate mode: strobe one edge after start
// - zero wait: acknowledge with delayed strobe
// - one to three waits counted after strobe
// - single mode hit: strobe, acknowledge one period later
// - burst write: strobe and acknowledge one period later
`default_nettype none
package dram_wcd_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int ROW_HOLD_NS    = 20;
  localparam int ROW_HOLD_FAST_NS = 12;
  // least times round up, never below one cycle
  localparam int ROW_HOLD_RAW   = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_FAST_RAW   = (ROW_HOLD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ROW_HOLD_CYC      = 4'((ROW_HOLD_RAW < 1) ? 1 : ROW_HOLD_RAW);
  localparam logic [3:0] ROW_HOLD_FAST_CYC = 4'((ROW_FAST_RAW < 1) ? 1 : ROW_FAST_RAW);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  CFG_OFFS     = 4'h0;
  localparam logic [3:0]  STAT_OFFS    = 4'h4;
  localparam logic [4:0]  CFG_RESET    = 5'h00;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_LAST_DLY  = 8;
  localparam int          STAT_CNT_LSB   = 16;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_DECERR  = 2'b11;

  typedef struct packed {
    logic [1:0] ack_wait;               // 0..3 waits after column strobe
    logic       alt_mode;               // 0 single access, 1 alternate
    logic       write_strobe_delay_bit;
    logic       row_hold_select_bit;
  } cfg_t;

  typedef struct packed {
    logic cycle_start;   // active high after inversion of the pin
    logic write;
    logic page_hit;
    logic burst;
  } proc_in_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic col_sel;
    logic transfer_ack_n;
  } mem_out_t;

  localparam mem_out_t MEM_IDLE = 4'hd;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ROW  = 3'b001,
    ST_DLY  = 3'b010,
    ST_CAS  = 3'b011,
    ST_HOLD = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    SEL_CFG  = 2'b00,
    SEL_STAT = 2'b01,
    SEL_NONE = 2'b10
  } reg_sel_t;

endpackage
`default_nettype wire

// File: test/proc_model.sv
`timescale 1ns/1ns
`default_nettype none
module proc_model
  import dram_wcd_pkg::*;
(
  input  wire logic     aclk,
  input  wire mem_out_t mem_pins,
  output var  logic     cycle_start_strobe_n,
  output var  logic     write_cycle,
  output var  logic     page_hit,
  output var  logic     burst_cycle
);
  // ----------------------------------------------------------------
  // processor side of one memory access
  // ----------------------------------------------------------------
  initial
  begin
    cycle_start_strobe_n = 1'b1;
    write_cycle          = 1'b0;
    page_hit             = 1'b0;
    burst_cycle          = 1'b0;
  end

  // called right after a rising edge; counts edges from the strobe fall
  task automatic access(input logic w, input logic h, input logic b,
                        output int cas_at, output int ack_at);
    int n;
    n = 0;
    cas_at = -1;
    ack_at = -1;
    cycle_start_strobe_n <= 1'b0;
    write_cycle          <= w;
    page_hit             <= h;
    burst_cycle          <= b;
    while (ack_at < 0 && n < 20)
    begin
      @(posedge aclk);
      n++;
      // values seen here were launched one edge earlier
      // the column strobe only counts with the row held and the column on the mux
      if (mem_pins.cas_n === 1'b0 && mem_pins.ras_n === 1'b0 && mem_pins.col_sel === 1'b1
          && cas_at < 0)
        cas_at = n - 1;
      if (mem_pins.transfer_ack_n === 1'b0)
        ack_at = n - 1;
    end
    // released qualifiers show the inverse so stale values are never trusted
    cycle_start_strobe_n <= 1'b1;
    write_cycle          <= ~w;
    page_hit             <= ~h;
    burst_cycle          <= ~b;
    n = 0;
    while (mem_pins.ras_n !== 1'b1 && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import dram_wcd_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic strobe_n, wr_c, hit_c, burst_c;
  mem_out_t mem_pins;
  int n_errors = 0, checked = 0, cyc = 0, n_dly = 0;

  always #50 aclk = ~aclk;

  dram_write_cas_delay uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cycle_start_strobe_n(strobe_n), .write_cycle(wr_c),
    .page_hit(hit_c), .burst_cycle(burst_c), .mem_pins(mem_pins));

  proc_model pm (.aclk(aclk), .mem_pins(mem_pins), .cycle_start_strobe_n(strobe_n),
    .write_cycle(wr_c), .page_hit(hit_c), .burst_cycle(burst_c));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // generous ceiling: the whole run needs well under 1000 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc > 4000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic set_cfg(input logic [1:0] aw, input logic alt, input logic dly,
                         input logic rsel);
    cfg_t c;
    logic [1:0] r;
    c = '{ack_wait: aw, alt_mode: alt, write_strobe_delay_bit: dly, row_hold_select_bit: rsel};
    axi_wr({4'h0, CFG_OFFS}, {27'h0, c}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic run(input logic w, input logic h, input logic b, input int e_cas,
                     input int aw);
    int cas_at, ack_at;
    pm.access(w, h, b, cas_at, ack_at);
    chk(cas_at, e_cas);
    chk(ack_at, e_cas + aw);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd({4'h0, CFG_OFFS}, d, r);
    chk(d, {27'h0, CFG_RESET});
    set_cfg(2'h3, 1'b1, 1'b1, 1'b1);
    axi_rd({4'h0, CFG_OFFS}, d, r);
    chk(d, 32'h0000_001f);
    axi_wr(8'h08, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, RESP_DECERR});
    axi_rd(8'h08, d, r);
    chk({r, d}, {RESP_DECERR, 32'h0});
  endtask

  // page-hit writes over every wait count, both modes, delay on and off
  task automatic t_hit_writes();
    for (int a = 0; a < 4; a++)
      for (int m = 0; m < 2; m++)
        for (int dl = 0; dl < 2; dl++)
        begin
          set_cfg(a[1:0], m[0], dl[0], 1'b0);
          run(1'b1, 1'b1, 1'b0, 3 + dl, a);
          n_dly += dl;
        end
  endtask

  task automatic t_other();
    logic [31:0] d;
    logic [1:0] r;
    set_cfg(2'h1, 1'b0, 1'b1, 1'b0);
    run(1'b0, 1'b1, 1'b0, 3, 1);
    run(1'b1, 1'b0, 1'b1, 4, 1);
    n_dly++;
    axi_rd({4'h0, STAT_OFFS}, d, r);
    chk(d, {n_dly[15:0], 16'h0100});
    run(1'b1, 1'b0, 1'b0, 4, 1);
    set_cfg(2'h0, 1'b1, 1'b1, 1'b1);
    run(1'b1, 1'b0, 1'b0, 4, 0);
    axi_rd({4'h0, STAT_OFFS}, d, r);
    chk(d, {n_dly[15:0], 16'h0000});
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_hit_writes();
    t_other();
    test_done();
  end
endmodule
`default_nettype wire

// File: verilog/dram_write_cas_delay.sv
`timescale 1ns/1ns
`default_nettype none
module dram_write_cas_delay
  import dram_wcd_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              cycle_start_strobe_n,
  input  wire logic              write_cycle,
  input  wire logic              page_hit,
  input  wire logic              burst_cycle,
  output var  mem_out_t          mem_pins
);

  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie in 5..32");
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = SEL_NONE;
    if (a[ADDR_W-1:4] == '0 && a[3:0] == CFG_OFFS)
      reg_sel = SEL_CFG;
    else if (a[ADDR_W-1:4] == '0 && a[3:0] == STAT_OFFS)
      reg_sel = SEL_STAT;
  endfunction

  cfg_t              cfg_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  state_t            state_q;
  mem_out_t          mem_q;
  logic [3:0]        row_cnt_q;
  logic [1:0]        wait_cnt_q;
  logic              last_dly_q;
  logic [15:0]       dly_cnt_q;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  wire aw_hs      = awvalid & awready_q;
  wire w_hs       = wvalid & wready_q;
  wire wr_fire    = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d  = (aw_full_q | aw_hs) & ~wr_fire;
  wire w_full_d   = (w_full_q | w_hs) & ~wr_fire;
  wire bvalid_d   = wr_fire | (bvalid_q & ~bready);
  wire ar_hs      = arvalid & arready_q;
  wire rvalid_d   = ar_hs | (rvalid_q & ~rready);
  wire reg_sel_t wsel = reg_sel(aw_addr_q);
  wire reg_sel_t rsel = reg_sel(araddr);
  wire cfg_wr     = wr_fire & (wsel == SEL_CFG) & w_strb_q[0];

  wire [31:0] stat_word = ({16'h0000, 13'h0000, 3'(state_q)} << STAT_STATE_LSB)
                        | ({31'h00000000, last_dly_q} << STAT_LAST_DLY)
                        | ({16'h0000, dly_cnt_q} << STAT_CNT_LSB);
  wire [31:0] rd_word   = (rsel == SEL_CFG)  ? {27'h0000000, cfg_q} :
                          (rsel == SEL_STAT) ? stat_word : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      if (aw_hs)
        aw_addr_q <= awaddr;
      if (w_hs)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
        bresp_q <= (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      rvalid_q  <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_hs)
      begin
        rdata_q <= rd_word;
        rresp_q <= (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  // config changes take hold at once; an access under way keeps its delay and row hold choice, and takes a new wait count only before its column strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q <= cfg_t'(CFG_RESET);
    else if (cfg_wr)
      cfg_q <= cfg_t'(w_data_q[4:0]);
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  proc_in_t req_s1_q;
  proc_in_t req_s2_q;
  logic     start_prev_q;

  wire proc_in_t req_pin = '{cycle_start: ~cycle_start_strobe_n, write: write_cycle,
                             page_hit: page_hit, burst: burst_cycle};

  // the processor holds qualifiers stable around the start strobe,
  // so all four share one two-stage synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_s1_q     <= '0;
      req_s2_q     <= '0;
      start_prev_q <= 1'b0;
    end
    else
    begin
      req_s1_q     <= req_pin;
      req_s2_q     <= req_s1_q;
      start_prev_q <= req_s2_q.cycle_start;
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  wire start_go  = (state_q == ST_IDLE) & req_s2_q.cycle_start & ~start_prev_q;
  wire col_path  = req_s2_q.page_hit | req_s2_q.burst;
  wire dly_w     = cfg_q.write_strobe_delay_bit & req_s2_q.write & col_path;
  wire [3:0] row_cyc = cfg_q.row_hold_select_bit ? ROW_HOLD_FAST_CYC : ROW_HOLD_CYC;
  wire ack_now   = (cfg_q.ack_wait == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q    <= ST_IDLE;
      mem_q      <= MEM_IDLE;
      row_cnt_q  <= 4'h0;
      wait_cnt_q <= 2'h0;
      last_dly_q <= 1'b0;
      dly_cnt_q  <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_go)
          begin
            mem_q.ras_n <= 1'b0;
            last_dly_q  <= dly_w;
            if (dly_w)
            begin
              dly_cnt_q <= dly_cnt_q + 16'h0001;
              state_q   <= ST_DLY;
            end
            else if (col_path)
            begin
              mem_q.col_sel        <= 1'b1;
              mem_q.cas_n          <= 1'b0;
              mem_q.transfer_ack_n <= ~ack_now;
              wait_cnt_q           <= cfg_q.ack_wait;
              state_q              <= ST_CAS;
            end
            else
            begin
              row_cnt_q <= row_cyc;
              state_q   <= ST_ROW;
            end
          end
        end
        ST_ROW:
        begin
          row_cnt_q <= row_cnt_q - 4'h1;
          if (row_cnt_q <= 4'h1)
          begin
            mem_q.col_sel        <= 1'b1;
            mem_q.cas_n          <= 1'b0;
            mem_q.transfer_ack_n <= ~ack_now;
            wait_cnt_q           <= cfg_q.ack_wait;
            state_q              <= ST_CAS;
          end
        end
        ST_DLY:
        begin
          // data has had a full period to settle at the array
          mem_q.col_sel        <= 1'b1;
          mem_q.cas_n          <= 1'b0;
          mem_q.transfer_ack_n <= ~ack_now;
          wait_cnt_q           <= cfg_q.ack_wait;
          state_q              <= ST_CAS;
        end
        ST_CAS:
        begin
          if (!mem_q.transfer_ack_n)
          begin
            mem_q.transfer_ack_n <= 1'b1;
            state_q              <= ST_HOLD;
          end
          else
          begin
            wait_cnt_q <= wait_cnt_q - 2'h1;
            if (wait_cnt_q == 2'h1)
              mem_q.transfer_ack_n <= 1'b0;
          end
        end
        ST_HOLD:
        begin
          if (!req_s2_q.cycle_start)
          begin
            mem_q   <= MEM_IDLE;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          mem_q   <= MEM_IDLE;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign awready  = awready_q;
  assign wready   = wready_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign arready  = arready_q;
  assign rvalid   = rvalid_q;
  assign rdata    = rdata_q;
  assign rresp    = rresp_q;
  assign mem_pins = mem_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  row_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && !col_path && cfg_q.row_hold_select_bit == 1'b0 && row_cyc == 4'h1
    |=> !mem_q.ras_n && !mem_q.col_sel && mem_q.cas_n ##1 mem_q.col_sel && !mem_q.cas_n)
    else $error("row address not held for the selected time");

  strobe_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && dly_w |=> mem_q.cas_n ##1 !mem_q.cas_n)
    else $error("column strobe not postponed by one period");

  ack_defer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && dly_w |=> mem_q.transfer_ack_n)
    else $error("acknowledge not deferred on delayed write");

  alt_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && cfg_q.alt_mode && cfg_q.write_strobe_delay_bit
      && req_s2_q.write && req_s2_q.page_hit
    |-> ##2 $fell(mem_q.cas_n))
    else $error("alternate mode strobe not one edge after start");

  zero_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && dly_w && cfg_q.ack_wait == 2'h0 |-> ##2 !mem_q.transfer_ack_n && !mem_q.cas_n)
    else $error("zero wait acknowledge not with column strobe");

  wait_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(mem_q.cas_n) && cfg_q.ack_wait == 2'h2 && $stable(cfg_q)
    |-> mem_q.transfer_ack_n[*2] ##1 !mem_q.transfer_ack_n)
    else $error("acknowledge wait count wrong");

  single_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && !cfg_q.alt_mode && dly_w && req_s2_q.page_hit && cfg_q.ack_wait == 2'h1
    |=> mem_q.cas_n ##1 !mem_q.cas_n && mem_q.transfer_ack_n ##1 !mem_q.transfer_ack_n)
    else $error("single mode hit not delayed one period");

  burst_dly_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && dly_w && req_s2_q.burst |=> (state_q == ST_DLY) ##1 (state_q == ST_CAS))
    else $error("burst write not delayed one period");

  no_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start_go && col_path && !req_s2_q.write |=> !mem_q.cas_n)
    else $error("read delayed by write strobe option");

endmodule
`default_nettype wire
